// File: rtl/sfs_pkg.sv
// Constants shared by the start-up fault sequencer.
package sfs_pkg;
   localparam int SFS_PEAK_COUNT = 6;
   localparam int SFS_CNT_W = 4;
   localparam logic [3:0] SFS_INIT_RAMPS = 4'h4;
   localparam logic [3:0] SFS_RAMP_GATE = 4'h2;
   localparam logic [3:0] SFS_RAMP_SOFT = 4'h3;
   localparam logic [3:0] SFS_PEAK_NEG = 4'h4;
   localparam logic [3:0] SFS_PEAK_DELAY = 4'h5;
   localparam logic [3:0] SFS_RAMP_POS = 4'h6;
   localparam int SFS_CLK_HZ = 10000000;
   localparam int SFS_SOFT_US = 2000;
   localparam int SFS_SOFT_CYC = SFS_SOFT_US * (SFS_CLK_HZ / 1000000);
   localparam int SFS_TIMEOUT_US = 50000;
   localparam int SFS_TIMEOUT_CYC = SFS_TIMEOUT_US * (SFS_CLK_HZ / 1000000);
   localparam int SFS_TMR_W = 20;
   typedef enum logic [6:0] {
      SFS_OFF      = 7'h01,
      SFS_WAIT_EN  = 7'h02,
      SFS_RISE     = 7'h04,
      SFS_FALL     = 7'h08,
      SFS_MONITOR  = 7'h10,
      SFS_TIMEOUT  = 7'h20,
      SFS_LATCHED  = 7'h40
   } sfs_state_type;
endpackage : sfs_pkg

// File: rtl/sfs_timer.sv
// Down counter that times the fault time-out ramp.
`timescale 1ns/100ps
module sfs_timer
   import sfs_pkg::*;
#(
   parameter int WIDTH = SFS_TMR_W
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Control.
   input wire logic run,
   input wire logic [WIDTH-1:0] load_value,
   // Status.
   output logic done
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic done_reg;
   logic done_next;

   // Counting restarts whenever run drops, which models the return to 1.15V.
   always_comb begin
      count_next = load_value;
      done_next = 1'b0;
      if (run) begin
         if (count_reg == '0) begin
            count_next = '0;
            done_next = 1'b1;
         end else begin
            count_next = count_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         done_reg <= done_next;
      end
   end

   assign done = done_reg;
endmodule : sfs_timer

// File: rtl/sfs_sequencer.sv
// Start-up sequencer and fault supervisor for a display power supply.
// Operation
// - A clean power-up counts exactly six peaks, releasing stages in order.
// - A latched fault stays off until enable toggles or supply recycles.
// - Enable low keeps everything powered down and idle.
// - Enable high and supply good start the timing ramp, fast then slow.
// - Enable low after supply good holds the first ramp off.
// - First four ramps set up protection switch and check timing cap, reference.
// - Reference and temperature are evaluated during the second ramp.
// - Inrush gate goes low at the second peak.
// - A fault turns the input protection transistor off.
// - Boost and logic soft-start begin at the third ramp start.
// - Negative rail enables at the fourth peak.
// - Delayed-output gate pulls low at the fifth peak.
// - Positive rail enables at the start of the sixth ramp.
// - After the sixth ramp, delayed output, gates and rails are checked.
// - Before soft-start, bad reference or temperature disables the device.
// - Stuck-low or stuck-high timing cap stops the sequence.
// - After start-up, timing cap, gates, feedbacks, reference are monitored.
// - In monitoring the timing cap is held at its rest level.
// - Timing cap, reference or temperature faults shut down immediately.
// - Other faults start a time-out ramp; reaching its end latches off.
// - A fault that clears before time-out returns to monitoring.
// - Gate signals not below threshold count as faulted.
// - Inrush gate not low after sequencing starts the time-out ramp.
`timescale 1ns/100ps
module sfs_sequencer
   import sfs_pkg::*;
#(
   parameter int TIMEOUT_CYC = SFS_TIMEOUT_CYC
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Enable and supply.
   input wire logic enable,
   input wire logic supply_good,
   // Timing capacitor comparator events.
   input wire logic cap_peak,
   input wire logic cap_valley,
   input wire logic cap_fault,
   // Analog status.
   input wire logic ref_ok,
   input wire logic temp_ok,
   input wire logic inrush_gate_high,
   input wire logic delayed_gate_high,
   input wire logic boost_fb_ok,
   input wire logic logic_fb_ok,
   input wire logic negative_fb_ok,
   input wire logic positive_fb_ok,
   // Timing capacitor drive.
   output logic cap_charge,
   output logic cap_fast,
   output logic cap_hold,
   output logic cap_timeout_ramp,
   // Stage controls.
   output logic inrush_gate_drive_n,
   output logic soft_start_en,
   output logic row_negative_rail_en,
   output logic delayed_output_gate_n,
   output logic row_positive_rail_en,
   // Status.
   output logic fault_latched,
   output logic sequence_done
);
   sfs_state_type state_reg;
   sfs_state_type state_next;
   logic [SFS_CNT_W-1:0] peaks_reg;
   logic [SFS_CNT_W-1:0] peaks_next;
   logic fast_reg;
   logic fast_next;
   logic gate_reg;
   logic gate_next;
   logic soft_reg;
   logic soft_next;
   logic neg_reg;
   logic neg_next;
   logic dly_reg;
   logic dly_next;
   logic pos_reg;
   logic pos_next;
   logic en_d_reg;
   logic sup_d_reg;
   logic rearm;
   logic hard_fault;
   logic soft_fault;
   logic timeout_done;

   assign rearm = (enable && !en_d_reg) || (supply_good && !sup_d_reg);
   assign hard_fault = cap_fault || !ref_ok || !temp_ok;
   assign soft_fault = inrush_gate_high || delayed_gate_high || !boost_fb_ok
      || !logic_fb_ok || !negative_fb_ok || !positive_fb_ok;

   sfs_timer #(
      .WIDTH(SFS_TMR_W)
   ) u_timer (
      .clock(clock),
      .nrst(nrst),
      .run(state_reg == SFS_TIMEOUT),
      .load_value(SFS_TMR_W'(TIMEOUT_CYC - 1)),
      .done(timeout_done)
   );

   always_comb begin
      state_next = state_reg;
      peaks_next = peaks_reg;
      fast_next = fast_reg;
      gate_next = gate_reg;
      soft_next = soft_reg;
      neg_next = neg_reg;
      dly_next = dly_reg;
      pos_next = pos_reg;
      unique case (state_reg)
         SFS_OFF: begin
            if (supply_good) begin
               state_next = SFS_WAIT_EN;
            end
         end
         SFS_WAIT_EN: begin
            if (enable) begin
               state_next = SFS_RISE;
               fast_next = 1'b1;
            end
         end
         SFS_RISE: begin
            if (cap_peak) begin
               peaks_next = peaks_reg + 1'b1;
               fast_next = 1'b0;
               state_next = SFS_FALL;
               if (peaks_next == SFS_RAMP_GATE) begin
                  gate_next = 1'b1;
               end
               if (peaks_next == SFS_PEAK_NEG) begin
                  neg_next = 1'b1;
               end
               if (peaks_next == SFS_PEAK_DELAY) begin
                  dly_next = 1'b1;
               end
               if (peaks_next == SFS_CNT_W'(SFS_PEAK_COUNT)) begin
                  state_next = SFS_MONITOR;
               end
            end
            if (peaks_reg == 4'h1 && (!ref_ok || !temp_ok)) begin
               state_next = SFS_LATCHED;
            end
         end
         SFS_FALL: begin
            if (cap_valley) begin
               state_next = SFS_RISE;
               if (peaks_reg == SFS_RAMP_SOFT - 4'h1) begin
                  soft_next = 1'b1;
               end
               if (peaks_reg == SFS_RAMP_POS - 4'h1) begin
                  pos_next = 1'b1;
               end
            end
         end
         SFS_MONITOR: begin
            if (soft_fault) begin
               state_next = SFS_TIMEOUT;
            end
         end
         SFS_TIMEOUT: begin
            if (!soft_fault) begin
               state_next = SFS_MONITOR;
            end else if (timeout_done) begin
               state_next = SFS_LATCHED;
            end
         end
         SFS_LATCHED: begin
            if (rearm) begin
               state_next = SFS_RISE;
               fast_next = 1'b1;
            end
         end
         default: begin
            state_next = SFS_OFF;
         end
      endcase
      // immediate faults during start and monitoring
      if (state_reg == SFS_RISE || state_reg == SFS_FALL
         || state_reg == SFS_MONITOR || state_reg == SFS_TIMEOUT) begin
         if (cap_fault || ((state_reg == SFS_MONITOR
            || state_reg == SFS_TIMEOUT) && hard_fault)
            || (peaks_reg >= SFS_RAMP_GATE && peaks_reg < SFS_INIT_RAMPS
            && !ref_ok)) begin
            state_next = SFS_LATCHED;
         end
      end
      if (state_reg == SFS_RISE && cap_peak
         && peaks_next == SFS_CNT_W'(SFS_PEAK_COUNT) && soft_fault
         && state_next == SFS_MONITOR) begin
         state_next = SFS_TIMEOUT;
      end
      if (state_next == SFS_LATCHED || state_next == SFS_WAIT_EN
         || (state_reg == SFS_LATCHED && state_next == SFS_RISE)) begin
         peaks_next = '0;
         gate_next = 1'b0;
         soft_next = 1'b0;
         neg_next = 1'b0;
         dly_next = 1'b0;
         pos_next = 1'b0;
      end
      if (!enable || !supply_good) begin
         state_next = supply_good ? SFS_WAIT_EN : SFS_OFF;
         peaks_next = '0;
         fast_next = 1'b0;
         gate_next = 1'b0;
         soft_next = 1'b0;
         neg_next = 1'b0;
         dly_next = 1'b0;
         pos_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= SFS_OFF;
         peaks_reg <= '0;
         fast_reg <= 1'b0;
         gate_reg <= 1'b0;
         soft_reg <= 1'b0;
         neg_reg <= 1'b0;
         dly_reg <= 1'b0;
         pos_reg <= 1'b0;
         en_d_reg <= 1'b0;
         sup_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         peaks_reg <= peaks_next;
         fast_reg <= fast_next;
         gate_reg <= gate_next;
         soft_reg <= soft_next;
         neg_reg <= neg_next;
         dly_reg <= dly_next;
         pos_reg <= pos_next;
         en_d_reg <= enable;
         sup_d_reg <= supply_good;
      end
   end

   assign cap_charge = (state_reg == SFS_RISE);
   assign cap_fast = fast_reg;
   assign cap_hold = (state_reg == SFS_MONITOR);
   assign cap_timeout_ramp = (state_reg == SFS_TIMEOUT);
   assign inrush_gate_drive_n = !gate_reg;
   assign delayed_output_gate_n = !dly_reg;
   assign soft_start_en = soft_reg;
   assign row_negative_rail_en = neg_reg;
   assign row_positive_rail_en = pos_reg;
   assign fault_latched = (state_reg == SFS_LATCHED);
   assign sequence_done = cap_hold || cap_timeout_ramp;

   property p_enable_off;
      @(posedge clock) disable iff (!nrst)
      !enable |=> (state_reg != SFS_RISE && !soft_reg && !pos_reg);
   endproperty
   a_enable_off: assert property (p_enable_off)
      else $error("stage active while enable low");

   property p_latch_holds;
      @(posedge clock) disable iff (!nrst)
      (state_reg == SFS_LATCHED && !rearm && enable && supply_good)
      |=> state_reg == SFS_LATCHED;
   endproperty
   a_latch_holds: assert property (p_latch_holds)
      else $error("latched state left without rearm");

   property p_gate_off_latched;
      @(posedge clock) disable iff (!nrst)
      state_reg == SFS_LATCHED |-> inrush_gate_drive_n;
   endproperty
   a_gate_off_latched: assert property (p_gate_off_latched)
      else $error("inrush gate on while latched");

   property p_pos_after_neg;
      @(posedge clock) disable iff (!nrst)
      $rose(pos_reg) |-> neg_reg && dly_reg && soft_reg;
   endproperty
   a_pos_after_neg: assert property (p_pos_after_neg)
      else $error("positive rail before earlier stages");

   property p_hard_fault;
      @(posedge clock) disable iff (!nrst)
      (state_reg == SFS_MONITOR && cap_fault && enable && supply_good)
      |=> state_reg == SFS_LATCHED;
   endproperty
   a_hard_fault: assert property (p_hard_fault)
      else $error("hard fault not immediate");

   property p_clear_returns;
      @(posedge clock) disable iff (!nrst)
      (state_reg == SFS_TIMEOUT && !soft_fault && !hard_fault && enable
      && supply_good) |=> state_reg == SFS_MONITOR;
   endproperty
   a_clear_returns: assert property (p_clear_returns)
      else $error("cleared fault did not return to monitor");

   property p_done_six;
      @(posedge clock) disable iff (!nrst)
      $rose(cap_hold) && $past(state_reg) == SFS_RISE |-> peaks_reg == 4'h6;
   endproperty
   a_done_six: assert property (p_done_six)
      else $error("monitor entered without six peaks");

   property p_neg_at_four;
      @(posedge clock) disable iff (!nrst)
      $rose(neg_reg) |-> peaks_reg == 4'h4;
   endproperty
   a_neg_at_four: assert property (p_neg_at_four)
      else $error("negative rail not at fourth peak");

   property p_gate_at_two;
      @(posedge clock) disable iff (!nrst)
      $rose(gate_reg) |-> peaks_reg == 4'h2;
   endproperty
   a_gate_at_two: assert property (p_gate_at_two)
      else $error("inrush gate not at second peak");
endmodule : sfs_sequencer

// File: tb/sfs_far_side.sv
// Far-side model: timing capacitor comparators, gate pins and rail feedback.
`timescale 1ns/100ps
module sfs_far_side #(
   parameter int RAMP = 10
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic nrst,
   // Drive from the sequencer.
   input wire logic cap_charge,
   input wire logic cap_hold,
   input wire logic cap_timeout_ramp,
   input wire logic inrush_gate_drive_n,
   input wire logic delayed_output_gate_n,
   input wire logic soft_start_en,
   input wire logic row_negative_rail_en,
   input wire logic row_positive_rail_en,
   // Faults commanded by the bench.
   input wire logic stuck_high,
   input wire logic rail_short,
   input wire logic gate_open,
   // Comparators and status.
   output logic cap_peak,
   output logic cap_valley,
   output logic inrush_gate_high,
   output logic delayed_gate_high,
   output logic boost_fb_ok,
   output logic logic_fb_ok,
   output logic negative_fb_ok,
   output logic positive_fb_ok
);
   logic up_reg;
   int cnt_reg;
   logic moving;
   logic charge_d_reg;
   // A stuck-high capacitor never falls, so no valley is ever seen.
   assign moving = (cap_charge && !up_reg) || (!cap_charge && up_reg &&
      !cap_hold && !cap_timeout_ramp && !stuck_high);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         up_reg <= 1'b0;
         cnt_reg <= 0;
         cap_peak <= 1'b0;
         cap_valley <= 1'b0;
         charge_d_reg <= 1'b0;
      end else begin
         cap_peak <= 1'b0;
         cap_valley <= 1'b0;
         cnt_reg <= 0;
         charge_d_reg <= cap_charge;
         // A capacitor left high by a shutdown has drained before recharge.
         if (cap_charge && !charge_d_reg && up_reg) begin
            up_reg <= 1'b0;
         end else if (moving && cnt_reg == RAMP) begin
            up_reg <= !up_reg;
            cap_peak <= !up_reg;
            cap_valley <= up_reg;
         end else if (moving) begin
            cnt_reg <= cnt_reg + 1;
         end
      end
   end
   // gate pin above threshold while not pulled low
   assign inrush_gate_high = inrush_gate_drive_n | gate_open;
   assign delayed_gate_high = delayed_output_gate_n;
   assign boost_fb_ok = soft_start_en & !rail_short;
   assign logic_fb_ok = soft_start_en;
   assign negative_fb_ok = row_negative_rail_en;
   assign positive_fb_ok = row_positive_rail_en;
endmodule : sfs_far_side

// File: tb/sfs_sequencer_tb.sv
// Self-checking bench for the start-up fault sequencer.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
   $display("mismatch %s exp %0h got %0h", nm, ex, gt); n_fail++; end end
module sfs_sequencer_tb;
   localparam int TMO = 20;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic enable = 1'b0;
   logic supply_good = 1'b0;
   logic cap_fault = 1'b0;
   logic ref_ok = 1'b1;
   logic temp_ok = 1'b1;
   logic stuck_high = 1'b0;
   logic rail_short = 1'b0;
   logic gate_open = 1'b0;
   logic cap_peak, cap_valley, inrush_gate_high, delayed_gate_high;
   logic boost_fb_ok, logic_fb_ok, negative_fb_ok, positive_fb_ok;
   logic cap_charge, cap_fast, cap_hold, cap_timeout_ramp;
   logic inrush_gate_drive_n, soft_start_en, row_negative_rail_en;
   logic delayed_output_gate_n, row_positive_rail_en;
   logic fault_latched, sequence_done;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   int n_peak = 0;
   int n_valley = 0;
   logic rec_clr = 1'b1;
   logic [7:0] at_gate, at_soft, at_neg, at_dly, at_pos;

   sfs_sequencer #(.TIMEOUT_CYC(TMO)) u_sfs_sequencer (.clock, .nrst,
      .enable, .supply_good, .cap_peak, .cap_valley, .cap_fault, .ref_ok,
      .temp_ok, .inrush_gate_high, .delayed_gate_high, .boost_fb_ok,
      .logic_fb_ok, .negative_fb_ok, .positive_fb_ok, .cap_charge, .cap_fast,
      .cap_hold, .cap_timeout_ramp, .inrush_gate_drive_n, .soft_start_en,
      .row_negative_rail_en, .delayed_output_gate_n, .row_positive_rail_en,
      .fault_latched, .sequence_done);
   sfs_far_side #(.RAMP(10)) u_sfs_far_side (.clock, .nrst, .cap_charge,
      .cap_hold, .cap_timeout_ramp, .inrush_gate_drive_n,
      .delayed_output_gate_n, .soft_start_en, .row_negative_rail_en,
      .row_positive_rail_en, .stuck_high, .rail_short, .gate_open, .cap_peak,
      .cap_valley, .inrush_gate_high, .delayed_gate_high, .boost_fb_ok,
      .logic_fb_ok, .negative_fb_ok, .positive_fb_ok);

   initial begin
      forever #50 clock = !clock;
   end

   // Records the peak and valley counts at which each stage first turns on.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (rec_clr) begin
         n_peak <= 0;
         n_valley <= 0;
         {at_gate, at_soft, at_neg, at_dly, at_pos} <= {5{8'hFF}};
      end else begin
         if (cap_peak === 1'b1) n_peak <= n_peak + 1;
         if (cap_valley === 1'b1) n_valley <= n_valley + 1;
         if (!inrush_gate_drive_n && at_gate === 8'hFF) at_gate <= snap();
         if (soft_start_en && at_soft === 8'hFF) at_soft <= snap();
         if (row_negative_rail_en && at_neg === 8'hFF) at_neg <= snap();
         if (!delayed_output_gate_n && at_dly === 8'hFF) at_dly <= snap();
         if (row_positive_rail_en && at_pos === 8'hFF) at_pos <= snap();
      end
   end

   function automatic logic [7:0] snap;
      return {n_peak[3:0], n_valley[3:0]};
   endfunction : snap

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   task automatic power_up;
      enable = 1'b0;
      rec_clr = 1'b1;
      cyc(2);
      rec_clr = 1'b0;
      enable = 1'b1;
      for (int i = 0; i < 600 && sequence_done !== 1'b1; i++) cyc(1);
   endtask : power_up

   task automatic t_off;
      supply_good = 1'b1;
      cyc(40);
      `CHK("charge", 1'b0, cap_charge)
      `CHK("inrush", 1'b1, inrush_gate_drive_n)
      `CHK("soft", 1'b0, soft_start_en)
      `CHK("done", 1'b0, sequence_done)
      $display("test off done");
   endtask : t_off

   task automatic t_startup;
      power_up;
      `CHK("gate at", 8'h21, at_gate)
      `CHK("soft at", 8'h22, at_soft)
      `CHK("neg at", 8'h43, at_neg)
      `CHK("delay at", 8'h54, at_dly)
      `CHK("pos at", 8'h55, at_pos)
      `CHK("hold", 1'b1, cap_hold)
      cyc(60);
      `CHK("peaks", 6, n_peak)
      `CHK("latched", 1'b0, fault_latched)
      $display("test startup done");
   endtask : t_startup

   task automatic t_timeout;
      rail_short = 1'b1;
      cyc(3);
      `CHK("tmo ramp", 1'b1, cap_timeout_ramp)
      cyc(5);
      rail_short = 1'b0;
      cyc(3);
      `CHK("hold back", 1'b1, cap_hold)
      gate_open = 1'b1;
      cyc(3);
      `CHK("gate tmo", 1'b1, cap_timeout_ramp)
      cyc(TMO - 5);
      `CHK("early", 1'b0, fault_latched)
      cyc(10);
      `CHK("latched", 1'b1, fault_latched)
      `CHK("inrush off", 1'b1, inrush_gate_drive_n)
      `CHK("rails off", 1'b0, row_positive_rail_en | soft_start_en)
      gate_open = 1'b0;
      cyc(10);
      `CHK("stays", 1'b1, fault_latched)
      power_up;
      `CHK("rearm", 1'b1, sequence_done)
      $display("test timeout done");
   endtask : t_timeout

   task automatic t_hard;
      logic [2:0] bad [3];
      bad = '{3'b111, 3'b001, 3'b010};
      for (int k = 0; k < 3; k++) begin
         power_up;
         {cap_fault, ref_ok, temp_ok} = bad[k];
         cyc(2);
         `CHK("hard", 1'b1, fault_latched)
         `CHK("no ramp", 1'b0, cap_timeout_ramp)
         {cap_fault, ref_ok, temp_ok} = 3'b011;
      end
      $display("test hard done");
   endtask : t_hard

   task automatic t_ref_start;
      ref_ok = 1'b0;
      power_up;
      `CHK("ref latched", 1'b1, fault_latched)
      `CHK("no soft", 8'hFF, at_soft)
      `CHK("inrush", 1'b1, inrush_gate_drive_n)
      ref_ok = 1'b1;
      $display("test reference done");
   endtask : t_ref_start

   task automatic t_stuck_supply;
      stuck_high = 1'b1;
      power_up;
      `CHK("stuck done", 1'b0, sequence_done)
      `CHK("valleys", 0, n_valley)
      stuck_high = 1'b0;
      supply_good = 1'b0;
      cyc(3);
      `CHK("supply off", 1'b0, cap_charge | inrush_gate_drive_n == 0)
      supply_good = 1'b1;
      cyc(3);
      `CHK("fast", 2'b11, {cap_charge, cap_fast})
      for (int i = 0; i < 600 && sequence_done !== 1'b1; i++) cyc(1);
      `CHK("resupply", 1'b1, sequence_done)
      $display("test stuck and supply done");
   endtask : t_stuck_supply

   task automatic test_done;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (16) @(negedge clock);
      nrst = 1'b1;
      fork
         begin
            t_off;
            t_startup;
            t_timeout;
            t_hard;
            t_ref_start;
            t_stuck_supply;
         end
         begin
            wait (cycles > 20000);
            $display("cycle limit reached");
            n_fail++;
         end
      join_any
      test_done;
   end
endmodule : sfs_sequencer_tb
